// [src/rmr_repeater.sv]
// Notes on behaviour
// [R1] Nine equal ports; data from the active port goes to all others.
// [R2] Line levels pass through logic with no character storage.
// [R3] The port whose start is seen first becomes the sole source.
// [R4] With a source chosen, all other drivers are on and carry its data.
// [R5] Drivers stay on after the last byte for the hold-off delay.
// [R6] At expiry all ports return to receive and wait for a new start.
// [R7] Four static select inputs choose the hold-off delay.
// [R8] Codes give 1.9 ms, 460 us, 140 us, 33 us, 9 us and 7 us.
// [R9] The installer matches the delay to the line rate.
// [R10] Each port has an activity output, high while it is receiving; here the source's stays high until the hold-off expires.
// [R11] Source idle ends reception; renewed activity restarts the delay.
// [R12] After reset drivers are off, ports receive, no source is chosen.
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
module rmr_repeater
	import rmr_pkg::*;
#(
	parameter int HOLD_LONG_CYC = HOLD_1900US_CYC,
	parameter int HOLD_DEF_CYC = HOLD_460US_CYC
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [NPORTS-1:0] line_in,
	output logic [NPORTS-1:0] line_out,
	output logic [NPORTS-1:0] line_oe,
	output logic [NPORTS-1:0] activity,
	input wire logic delay_select_0,
	input wire logic delay_select_1,
	input wire logic delay_select_2,
	input wire logic delay_select_3
);

	// Lowest-numbered low line; only meaningful when some line is low.
	function automatic logic [IDXW-1:0] first_low(
		input logic [NPORTS-1:0] v);
		logic [IDXW-1:0] r;
		r = '0;
		for (int i = NPORTS - 1; i >= 0; i--) begin
			if (v[i] != LINE_IDLE) begin
				r = IDXW'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [NPORTS-1:0] port_bit(
		input logic [IDXW-1:0] idx);
		logic [NPORTS-1:0] r;
		r = '0;
		for (int i = 0; i < NPORTS; i++) begin
			r[i] = (idx == IDXW'(i));
		end
		return r;
	endfunction

	// Unlisted select codes fall back to the default 460 us.
	function automatic logic [CNTW-1:0] sel_limit(input logic [3:0] s);
		case (s)
			SEL_1900US: sel_limit = CNTW'(HOLD_LONG_CYC);
			SEL_460US: sel_limit = CNTW'(HOLD_DEF_CYC);
			SEL_140US: sel_limit = CNTW'(HOLD_140US_CYC);
			SEL_33US: sel_limit = CNTW'(HOLD_33US_CYC);
			SEL_9US: sel_limit = CNTW'(HOLD_9US_CYC);
			SEL_7US: sel_limit = CNTW'(HOLD_7US_CYC);
			default: sel_limit = CNTW'(HOLD_DEF_CYC);
		endcase
	endfunction

	logic [3:0] delay_sel;
	logic [CNTW-1:0] hold_limit;
	logic hold_done;
	logic [CNTW-1:0] hold_count;
	logic src_low;
	logic busy;
	rmr_state_t state_q, state_d;
	logic [IDXW-1:0] src_q, src_d;
	logic [NPORTS-1:0] out_q, out_d, oe_q, oe_d, act_q, act_d;
	logic [NPORTS-1:0] lin_q, lin_d;
	logic [31:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
	logic wpend_q, wpend_d;
	logic [7:0] waddr_q, waddr_d;

	// Static select inputs are decoded every cycle. [R7] [R8]
	assign delay_sel = {delay_select_3, delay_select_2,
		delay_select_1, delay_select_0};
	assign hold_limit = sel_limit(delay_sel); // [R8]
	assign busy = (state_q == ST_REPEAT);
	assign src_low = (line_in[src_q] != LINE_IDLE);

	// Source low restarts the hold-off; idle cycles count it up to the limit.
	rmr_hold_timer u_hold (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(busy),
		.restart(src_low), // [R11]
		.limit(hold_limit),
		.done(hold_done),
		.count(hold_count)
	);

	// Arbitration and turnaround; same-cycle starts go to lowest index.
	always_comb begin
		state_d = state_q;
		src_d = src_q;
		case (state_q)
			ST_LISTEN: begin
				if (ctrl_q[CTRL_ENABLE_BIT] && (~line_in != '0)) begin
					state_d = ST_REPEAT; // [R3]
					src_d = first_low(line_in); // [R3]
				end
			end
			ST_REPEAT: begin
				if (hold_done) begin
					state_d = ST_LISTEN; // [R5] [R6]
				end
			end
			default: state_d = ST_LISTEN;
		endcase
	end

	// Line outputs follow the source level with one flop of latency,
	// so a bit is delayed by one clock and never stored longer.
	always_comb begin
		lin_d = line_in; // Sampled levels for the checks below.
		if (state_d == ST_REPEAT) begin
			oe_d = ~port_bit(src_d); // [R4]
			out_d = {NPORTS{line_in[src_d]}} | port_bit(src_d); // [R1] [R2]
			act_d = port_bit(src_d); // [R10]
		end else begin
			oe_d = '0; // [R6]
			out_d = {NPORTS{LINE_IDLE}};
			act_d = '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_LISTEN; // [R12]
			src_q <= '0;
			oe_q <= '0; // [R12]
			out_q <= '1;
			act_q <= '0;
			lin_q <= {NPORTS{LINE_IDLE}};
		end else begin
			state_q <= state_d;
			src_q <= src_d;
			oe_q <= oe_d;
			out_q <= out_d;
			act_q <= act_d;
			lin_q <= lin_d;
		end
	end

	// Bus slave: zero wait states, read data prepared in address phase.
	always_comb begin
		logic take;
		take = hsel && hready && htrans[1];
		wpend_d = take && hwrite;
		waddr_d = take ? haddr[7:0] : waddr_q;
		ctrl_d = ctrl_q;
		rdata_d = rdata_q;
		if (wpend_q && waddr_q == REG_CTRL) begin
			ctrl_d = {31'h0000_0000, hwdata[CTRL_ENABLE_BIT]};
		end
		if (take && !hwrite) begin
			case (haddr[7:0])
				// A write still in its data phase is forwarded, so a
				// back-to-back read does not return the stale value.
				REG_CTRL: rdata_d = ctrl_d;
				REG_STATUS: begin
					rdata_d = '0;
					rdata_d[STAT_BUSY_BIT] = busy;
					rdata_d[STAT_SRC_LSB +: IDXW] = src_q;
					rdata_d[STAT_ACT_LSB +: NPORTS] = act_q;
				end
				REG_SELECT: rdata_d = {28'h000_0000, delay_sel};
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RESET;
			rdata_q <= '0;
			wpend_q <= 1'b0;
			waddr_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			wpend_q <= wpend_d;
			waddr_q <= waddr_d;
		end
	end

	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign line_out = out_q;
	assign line_oe = oe_q;
	assign activity = act_q;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// The chosen source was low at the deciding edge and no lower port was.
	property p_first_start;
		!busy && ctrl_q[CTRL_ENABLE_BIT] && (~line_in != '0)
			|=> busy && lin_q[src_q] != LINE_IDLE
			&& (~lin_q & (port_bit(src_q) - 9'h001)) == '0;
	endproperty
	a_first_start: assert property (p_first_start) // [R3]
		else $error("first start did not become the source");

	property p_oe_others;
		$rose(busy) |-> oe_q == ~port_bit(src_q) ##1 oe_q == ~port_bit(src_q);
	endproperty
	a_oe_others: assert property (p_oe_others) // [R4]
		else $error("non-source drivers not enabled");

	property p_forward;
		busy && $past(busy) |-> out_q[src_q] == 1'b1
			&& (out_q & ~port_bit(src_q))
			== ({NPORTS{lin_q[src_q]}} & ~port_bit(src_q));
	endproperty
	a_forward: assert property (p_forward) // [R1]
		else $error("source level not forwarded to other ports");

	property p_hold_after_low;
		busy && src_low |=> busy [*2];
	endproperty
	a_hold_after_low: assert property (p_hold_after_low) // [R5]
		else $error("drivers dropped right after source activity");

	property p_release;
		busy && hold_done |=> !busy && oe_q == '0 && act_q == '0;
	endproperty
	a_release: assert property (p_release) // [R6]
		else $error("ports not returned to receive at expiry");

	// Release comes exactly when the idle count has reached the limit.
	property p_hold_length;
		busy ##1 !busy |-> hold_count == hold_limit;
	endproperty
	a_hold_length: assert property (p_hold_length) // [R8]
		else $error("hold-off ended at wrong count");

	property p_restart;
		busy && src_low |=> hold_count == '0;
	endproperty
	a_restart: assert property (p_restart) // [R11]
		else $error("source activity did not restart the delay");

	property p_activity;
		busy |-> act_q == port_bit(src_q) && !oe_q[src_q];
	endproperty
	a_activity: assert property (p_activity) // [R10]
		else $error("activity does not mark the source port");

	property p_quiet_idle;
		!busy |-> oe_q == '0 && out_q == '1;
	endproperty
	a_quiet_idle: assert property (p_quiet_idle) // [R12]
		else $error("driver on while no source selected");

	property p_default_sel;
		delay_sel == SEL_460US |-> hold_limit == CNTW'(HOLD_DEF_CYC);
	endproperty
	a_default_sel: assert property (p_default_sel) // [R7]
		else $error("default select code gives wrong delay");

endmodule // rmr_repeater

// [src/rmr_pkg.sv]
package rmr_pkg;

	// Port count and index width.
	localparam int NPORTS = 9;
	localparam int IDXW = 4;
	localparam int CNTW = 16;

	// Clock and hold-off times, in nanoseconds.
	localparam int CLK_PERIOD_NS = 40;
	localparam int HOLD_1900US_NS = 1900000;
	localparam int HOLD_460US_NS = 460000;
	localparam int HOLD_140US_NS = 140000;
	localparam int HOLD_33US_NS = 33000;
	localparam int HOLD_9US_NS = 9000;
	localparam int HOLD_7US_NS = 7000;

	// Hold-off times as clock cycles.
	localparam int HOLD_1900US_CYC = HOLD_1900US_NS / CLK_PERIOD_NS;
	localparam int HOLD_460US_CYC = HOLD_460US_NS / CLK_PERIOD_NS;
	localparam int HOLD_140US_CYC = HOLD_140US_NS / CLK_PERIOD_NS;
	localparam int HOLD_33US_CYC = HOLD_33US_NS / CLK_PERIOD_NS;
	localparam int HOLD_9US_CYC = HOLD_9US_NS / CLK_PERIOD_NS;
	localparam int HOLD_7US_CYC = HOLD_7US_NS / CLK_PERIOD_NS;

	// Delay select codes, bit 0 is delay_select_0.
	localparam logic [3:0] SEL_1900US = 4'h0;
	localparam logic [3:0] SEL_460US = 4'h1;
	localparam logic [3:0] SEL_140US = 4'h2;
	localparam logic [3:0] SEL_33US = 4'h4;
	localparam logic [3:0] SEL_9US = 4'h8;
	localparam logic [3:0] SEL_7US = 4'hc;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SELECT = 8'h08;

	// Field positions and reset values.
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_SRC_LSB = 4;
	localparam int STAT_ACT_LSB = 16;

	// Line level while nobody drives: mark, logic one.
	localparam logic LINE_IDLE = 1'b1;

	typedef enum logic [0:0] {
		ST_LISTEN,
		ST_REPEAT
	} rmr_state_t;

endpackage

// [src/rmr_hold_timer.sv]
module rmr_hold_timer
	import rmr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic restart,
	input wire logic [CNTW-1:0] limit,
	output logic done,
	output logic [CNTW-1:0] count
);

	logic [CNTW-1:0] cnt_q;
	logic [CNTW-1:0] cnt_d;

	// Counts idle cycles; source activity (restart) or a stop clears the count.
	always_comb begin
		cnt_d = cnt_q;
		if (!run || restart) begin
			cnt_d = '0;
		end else if (cnt_q != limit) begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Done when the count is about to reach the limit this cycle.
	assign done = run && !restart && (cnt_q == limit - 16'h0001);
	assign count = cnt_q;

endmodule // rmr_hold_timer

// [bench/rmr_far_end.sv]
module rmr_far_end
	import rmr_pkg::*;
(
	input wire logic [NPORTS-1:0] line_out,
	input wire logic [NPORTS-1:0] line_oe,
	input wire logic [NPORTS-1:0] drv_low,
	output logic [NPORTS-1:0] line_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// A driven port shows the repeater's level; an undriven one is pulled
	// low by its remote device or held at mark by the bias resistors.
	// Only the contention test lets a remote device talk while its port is driven (port 8).
	always_comb begin
		for (int i = 0; i < NPORTS; i++) begin
			line_in[i] = line_oe[i] ? line_out[i] :
				(drv_low[i] ? 1'b0 : LINE_IDLE);
		end
	end
endmodule // rmr_far_end

// [bench/rs485_multiport_repeater_bench.sv]
module rs485_multiport_repeater_bench
	import rmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// Short hold counts keep the run brief; expectations follow them.
	localparam int LONG = 40;
	localparam int DEF = 30;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] dsel;
	logic [NPORTS-1:0] line_in, line_out, line_oe, activity, drv;
	int err_total, checked, n;
	logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hc, 4'h3};
	int lims [7] = '{LONG, DEF, 3500, 825, 225, 175, DEF};

	rmr_repeater #(.HOLD_LONG_CYC(LONG), .HOLD_DEF_CYC(DEF)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .line_in(line_in), .line_out(line_out),
		.line_oe(line_oe), .activity(activity),
		.delay_select_0(dsel[0]), .delay_select_1(dsel[1]),
		.delay_select_2(dsel[2]), .delay_select_3(dsel[3]));

	rmr_far_end i_far (.line_out(line_out), .line_oe(line_oe),
		.drv_low(drv), .line_in(line_in));

	// Free-running 25 MHz system clock.
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Waits for hready at a rising edge; a stuck slave ends the run.
	task automatic wait_rdy;
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			k++;
			if (k > 64) begin
				err_total++;
				report_and_stop;
			end
			@(posedge hclk);
		end
	endtask

	// One single-word transfer; read data lands in rd.
	task automatic ahb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
		hsel <= 1'b0;
	endtask

	// Counts cycles that the drivers stay on after the source goes idle.
	task automatic hold(input int lim);
		n = 0;
		@(posedge hclk);
		#1;
		while (line_oe !== 9'h0 && n < 5000) begin
			n++;
			@(posedge hclk);
			#1;
		end
		// A hold that never ends is a failure of its own.
		if (n >= 5000) begin
			err_total++;
			report_and_stop;
		end
		check(32'(n >= lim - 1 && n <= lim + 2), 32'h1);
		check(line_out, 9'h1ff);
		check(activity, 9'h0);
	endtask

	// Start on port p under select code s, check repeating, then the hold.
	task automatic run(input int p, input logic [3:0] s, input int lim);
		logic [8:0] one;
		one = 9'h1 << p;
		@(posedge hclk);
		dsel <= s;
		drv <= one;
		@(posedge hclk);
		#1;
		check(line_oe, {23'h0, ~one});
		check(activity, {23'h0, one});
		check(line_out & ~one, 9'h0);
		@(posedge hclk);
		drv <= 9'h0;
		hold(lim);
	endtask

	// Guards against a hang anywhere in the sequence.
	initial begin
		repeat (100000) @(posedge hclk);
		err_total++;
		report_and_stop;
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		// The installer's default setting, meant for 19200 to 38400 Bd.
		dsel = 4'h1;
		drv = 9'h0;
		err_total = 0;
		checked = 0;
		repeat (6) @(posedge hclk);
		check(line_oe, 9'h0);
		check(line_out, 9'h1ff);
		hresetn <= 1'b1;
		ahb(1'b0, REG_CTRL, 32'h0);
		check(rd, CTRL_RESET);
		ahb(1'b0, REG_SELECT, 32'h0);
		check(rd, 32'h1);
		$display("reset test done");
		for (int i = 0; i < 7; i++) begin
			run(i, codes[i], lims[i]);
		end
		$display("delay table test done");
		// Two ports start in one cycle; the lower index is taken.
		@(posedge hclk);
		dsel <= 4'h1;
		drv <= 9'h120;
		@(posedge hclk);
		#1;
		check(line_oe, 9'h1df);
		check(activity, 9'h020);
		ahb(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'h0020_0051);
		@(posedge hclk);
		drv <= 9'h0;
		hold(DEF);
		$display("contention test done");
		// Renewed activity mid-hold restarts the full count.
		@(posedge hclk);
		drv <= 9'h008;
		@(posedge hclk);
		drv <= 9'h0;
		repeat (DEF - 10) @(posedge hclk);
		drv <= 9'h008;
		repeat (2) @(posedge hclk);
		drv <= 9'h0;
		hold(DEF);
		$display("restart test done");
		// With repeating switched off a start is ignored.
		ahb(1'b1, REG_CTRL, 32'h0);
		@(posedge hclk);
		drv <= 9'h010;
		repeat (3) @(posedge hclk);
		#1;
		check(line_oe, 9'h0);
		ahb(1'b0, REG_STATUS, 32'h0);
		check(rd[0], 1'b0);
		@(posedge hclk);
		drv <= 9'h0;
		ahb(1'b1, REG_CTRL, 32'h1);
		ahb(1'b0, 8'h0c, 32'h0);
		check(rd, 32'h0);
		$display("enable and map test done");
		report_and_stop;
	end
endmodule // rs485_multiport_repeater_bench
